// [dv/host_tool.sv]
// host programming tool model: frames commands and collects reply bytes
`timescale 1ns/1ps
`default_nettype none
module host_tool (
    input wire logic clk,
    output logic rx_valid,
    output logic [7:0] rx_data,
    input wire logic rx_ready,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_ready
);
    logic [7:0] reply_q[$];
    logic slow = 1'b0;
    logic [7:0] cmd_code = 8'h51;
    initial begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
        tx_ready = 1'b0;
    end
    // offer a byte right after an edge, hold it until the edge that takes it
    task automatic send_byte(input logic [7:0] b, output bit ok);
        ok = 1'b0;
        rx_valid <= 1'b1;
        rx_data <= b;
        for (int i = 0; i < 50 && !ok; i++) begin
            @(posedge clk);
            ok = (rx_ready === 1'b1);
        end
    endtask
    // stray byte first, then the framed command with its check byte
    task automatic send_cmd(input logic [7:0] length_low_byte, id, val, sd, trl, output bit ok);
        logic [7:0] p[$];
        logic [7:0] s;
        p = {8'h55, 8'h01, 8'h00, length_low_byte, cmd_code, id, val};
        if (length_low_byte == 8'h04) p.push_back(8'h00);
        s = 8'h00;
        for (int i = 2; i < p.size(); i++) s += p[i];
        p.push_back(8'h00 - s + sd);
        p.push_back(trl);
        ok = 1'b1;
        foreach (p[i]) if (ok) send_byte(p[i], ok);
        // a released line shows the inverse so a stale byte cannot pass
        rx_valid <= 1'b0;
        rx_data <= ~rx_data;
    endtask
    // take reply bytes; slow mode stalls every other cycle
    always @(posedge clk) begin
        if (tx_valid && tx_ready) reply_q.push_back(tx_data);
        tx_ready <= slow ? ~tx_ready : 1'b1;
    end
endmodule
`default_nettype wire

// [dv/tb.sv]
// self-checking bench for the parameter setting command handler
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam logic [31:0] UW = 32'h0FFF_FFFF;
    localparam logic [31:0] FST = 32'h0000_5A5A; // arbitrary flash status
    logic clk, arst_n = 1'b0;
    logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hF, stored_settings = 4'h0;
    logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, d;
    logic rx_valid, rx_ready, tx_valid, tx_ready, flash_req;
    logic [7:0] rx_data, tx_data, flash_param_id, last_fid;
    logic lifecycle_permit = 1'b1, enc_write_no_reset = 1'b0;
    logic [1:0] auth_level = 2'h0, fcnt = 2'h0;
    logic flash_done = 1'b0, flash_fail = 1'b0;
    logic ia, bla, rra, l2a, l1a;
    int failures = 0, checks_done = 0, flash_n = 0;
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    param_set_handler param_set_handler_i (.clk(clk), .arst_n(arst_n),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
        .lifecycle_permit(lifecycle_permit), .auth_level(auth_level),
        .enc_write_no_reset(enc_write_no_reset), .stored_settings(stored_settings),
        .flash_req(flash_req), .flash_param_id(flash_param_id), .flash_done(flash_done),
        .flash_fail(flash_fail), .flash_status(FST), .init_allowed(ia),
        .boot_lock_allowed(bla), .return_request_allowed(rra),
        .level_two_key_allowed(l2a), .level_one_key_allowed(l1a));
    host_tool host_tool_i (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
    // flash stand-in: answers each request with a done pulse after four cycles
    always @(posedge clk) begin
        flash_done <= flash_req && fcnt == 2'h3;
        fcnt <= flash_req ? fcnt + 2'h1 : 2'h0;
        if (flash_req && fcnt == 2'h3) begin
            flash_n <= flash_n + 1;
            last_fid <= flash_param_id;
        end
    end
    task automatic close_out();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic hang();
        failures++;
        $display("[ERR] %0t wait ran out %h %h", $time, 1'b0, 1'b1);
        close_out();
    endtask
    task automatic cmp_byte(input logic [7:0] g, e);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic cmp_word(input logic [31:0] g, e);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    // avalon access: hold the request until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd,
        input logic [3:0] be);
        bit ok;
        ok = 1'b0;
        avs_read <= ~wr;
        avs_write <= wr;
        avs_address <= a;
        avs_writedata <= wd;
        avs_byteenable <= be;
        for (int i = 0; i < 20 && !ok; i++) begin
            @(posedge clk);
            ok = (avs_waitrequest === 1'b0);
        end
        if (!ok) hang();
        d = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        // let an edge pass so a following call never re-raises in this step
        @(posedge clk);
    endtask
    // one command exchange, the full reply compared byte by byte
    task automatic run(input logic [7:0] length_low_byte, id, val, sd, trl, sts, input logic [31:0] det);
        logic [7:0] e[15];
        logic [7:0] s;
        bit ok;
        host_tool_i.reply_q.delete();
        host_tool_i.slow = ~host_tool_i.slow;
        @(posedge clk);
        host_tool_i.send_cmd(length_low_byte, id, val, sd, trl, ok);
        if (!ok) hang();
        e = '{8'h81, 8'h00, 8'h0A, (sts == 8'h00) ? 8'h51 : 8'hD1, sts, det[31:24],
            det[23:16], det[15:8], det[7:0], 8'h0F, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h03};
        s = 8'h00;
        for (int i = 1; i < 13; i++) s += e[i];
        e[13] = 8'h00 - s;
        for (int i = 0; i < 2000 && host_tool_i.reply_q.size() < 15; i++) @(posedge clk);
        if (host_tool_i.reply_q.size() < 15) hang();
        for (int i = 0; i < 15; i++) cmp_byte(host_tool_i.reply_q[i], e[i]);
    endtask
    initial begin
        bit ok;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        bus(1'b0, 4'h0, 32'h0, 4'hF);
        cmp_word(d, 32'h0000_0001);
        bus(1'b0, 4'h1, 32'h0, 4'hF);
        cmp_word(d, 32'h0000_0000);
        bus(1'b1, 4'h0, 32'h0, 4'h0);
        bus(1'b1, 4'h0, 32'h0, 4'h1);
        cmp_byte({7'h0, rx_ready}, 8'h00);
        bus(1'b1, 4'h0, 32'h1, 4'h1);
        bus(1'b0, 4'h0, 32'h0, 4'hF);
        cmp_word(d, 32'h0000_0001);
        run(8'h03, 8'h01, 8'hF8, 8'h00, 8'h03, 8'h00, UW);
        cmp_byte({7'h0, ia}, 8'h00);
        run(8'h03, 8'h01, 8'h00, 8'h00, 8'h03, 8'h00, UW);
        run(8'h03, 8'h02, 8'h00, 8'h00, 8'h03, 8'hD0, UW);
        auth_level <= 2'h1;
        run(8'h03, 8'h03, 8'h00, 8'h00, 8'h03, 8'hD0, UW);
        flash_fail <= 1'b1;
        run(8'h03, 8'h02, 8'h00, 8'h00, 8'h03, 8'hE1, FST);
        bus(1'b0, 4'h8, 32'h0, 4'hF);
        cmp_word(d, 32'h0000_0001);
        flash_fail <= 1'b0;
        run(8'h03, 8'h02, 8'h00, 8'h00, 8'h03, 8'h00, UW);
        cmp_byte({7'h0, bla}, 8'h00);
        enc_write_no_reset <= 1'b1;
        run(8'h03, 8'h04, 8'h00, 8'h00, 8'h03, 8'hC3, UW);
        enc_write_no_reset <= 1'b0;
        run(8'h03, 8'h05, 8'h00, 8'h00, 8'h03, 8'hC5, UW);
        run(8'h03, 8'h04, 8'h01, 8'h00, 8'h03, 8'hC5, UW);
        bus(1'b0, 4'h4, 32'h0, 4'hF);
        cmp_word(d, 32'h0000_D1C5);
        run(8'h03, 8'h04, 8'h00, 8'h01, 8'h03, 8'hC2, UW);
        run(8'h03, 8'h04, 8'h00, 8'h00, 8'h02, 8'hC1, UW);
        run(8'h03, 8'h04, 8'h00, 8'h01, 8'h02, 8'hC1, UW);
        run(8'h04, 8'h04, 8'h00, 8'h00, 8'h03, 8'hC1, UW);
        run(8'h00, 8'h04, 8'h00, 8'h00, 8'h03, 8'hC1, UW);
        lifecycle_permit <= 1'b0;
        run(8'h03, 8'h05, 8'h00, 8'h00, 8'h03, 8'hC3, UW);
        lifecycle_permit <= 1'b1;
        run(8'h03, 8'h04, 8'h00, 8'h00, 8'h03, 8'h00, UW);
        cmp_byte(last_fid, 8'h04);
        auth_level <= 2'h2;
        run(8'h03, 8'h03, 8'h00, 8'h00, 8'h03, 8'h00, UW);
        cmp_byte({3'h0, ia, rra, l2a, l1a, bla}, 8'h00);
        bus(1'b0, 4'h8, 32'h0, 4'hF);
        cmp_word(d, 32'h0000_000F);
        bus(1'b0, 4'hC, 32'h0, 4'hF);
        cmp_word(d, FST);
        // a foreign command code is dropped without any reply
        host_tool_i.reply_q.delete();
        host_tool_i.cmd_code = 8'h52;
        host_tool_i.send_cmd(8'h03, 8'h01, 8'h00, 8'h00, 8'h03, ok);
        if (!ok) hang();
        repeat (40) @(posedge clk);
        cmp_word(32'(host_tool_i.reply_q.size()), 32'h0000_0000);
        bus(1'b0, 4'h4, 32'h0, 4'hF);
        cmp_word(d, 32'h0000_5100);
        cmp_word(32'(flash_n), 32'h0000_0005);
        arst_n <= 1'b0;
        stored_settings <= 4'h4;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge clk);
        cmp_byte({5'h0, ia, rra, l1a}, 8'h01);
        bus(1'b0, 4'h8, 32'h0, 4'hF);
        cmp_word(d, 32'h0000_0004);
        close_out();
    end
endmodule
`default_nettype wire

// [rtl/param_set_handler.sv]
// parameter setting command handler with avalon register slave
`timescale 1ns/1ps
`default_nettype none

module param_set_handler #(
    parameter logic [15:0] MAX_LEN = param_set_pkg::MAX_LEN_DEFAULT
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    output logic rx_ready,
    output logic tx_valid,
    output logic [7:0] tx_data,
    input wire logic tx_ready,
    input wire logic lifecycle_permit,
    input wire logic [1:0] auth_level,
    input wire logic enc_write_no_reset,
    input wire logic [3:0] stored_settings,
    output logic flash_req,
    output logic [7:0] flash_param_id,
    input wire logic flash_done,
    input wire logic flash_fail,
    input wire logic [31:0] flash_status,
    output logic init_allowed,
    output logic boot_lock_allowed,
    output logic return_request_allowed,
    output logic level_two_key_allowed,
    output logic level_one_key_allowed
);
    typedef enum logic [3:0] {
        ST_WAIT, ST_LEN_H, ST_LEN_L, ST_BODY, ST_SUM, ST_ETX,
        ST_EVAL, ST_FLASH, ST_SEND
    } state_t;

    state_t state_r;
    logic [15:0] len_r;
    logic [15:0] body_cnt_r;
    logic [7:0] sum_r;
    logic [7:0] cmd_r;
    logic [7:0] pid_r;
    logic [7:0] pval_r;
    logic etx_ok_r;
    logic [7:0] rsp_code_r;
    logic [7:0] sts_r;
    logic [31:0] detail_r;
    logic [3:0] idx_r;
    logic [7:0] tx_sum_r;
    logic [7:0] tx_data_r;
    logic tx_valid_r;
    logic [3:0] disabled_r;
    logic loaded_r;
    logic enable_r;
    logic [31:0] flash_sts_r;
    logic ack_r;
    logic [31:0] rdata_r;
    logic rx_take;
    logic fmt_ok;
    logic [15:0] body_len;
    logic pid_ok;
    logic auth_ok;
    logic already;
    logic drop;
    logic go_flash;
    logic [7:0] eval_sts;
    logic [7:0] reply_byte;
    logic [3:0] pid_bit;

    // length outside the general format is parsed as the expected length
    assign fmt_ok = (len_r != 16'h0000) && (len_r <= MAX_LEN);
    assign body_len = fmt_ok ? len_r : param_set_pkg::CMD_LEN;
    assign rx_ready = enable_r && (state_r inside {ST_WAIT, ST_LEN_H, ST_LEN_L,
        ST_BODY, ST_SUM, ST_ETX});
    assign rx_take = rx_valid && rx_ready;

    // identifier decode to a one-hot setting bit
    always_comb begin
        pid_bit = 4'h0;
        pid_ok = 1'b1;
        unique case (pid_r)
            param_set_pkg::PID_INIT: pid_bit[param_set_pkg::BIT_INIT] = 1'b1;
            param_set_pkg::PID_BOOT_LOCK: pid_bit[param_set_pkg::BIT_BOOT_LOCK] = 1'b1;
            param_set_pkg::PID_L2_KEY: pid_bit[param_set_pkg::BIT_L2_KEY] = 1'b1;
            param_set_pkg::PID_L1_KEY: pid_bit[param_set_pkg::BIT_L1_KEY] = 1'b1;
            default: pid_ok = 1'b0;
        endcase
    end

    // level needed per identifier
    always_comb begin
        auth_ok = 1'b0;
        unique case (pid_r)
            param_set_pkg::PID_INIT: auth_ok = 1'b1;
            param_set_pkg::PID_L2_KEY: auth_ok = (auth_level == param_set_pkg::AUTH_LEVEL_TWO);
            default: auth_ok = (auth_level == param_set_pkg::AUTH_LEVEL_TWO)
                || (auth_level == param_set_pkg::AUTH_LEVEL_ONE);
        endcase
    end

    assign already = |(pid_bit & disabled_r);

    // checks in falling priority, first hit wins
    always_comb begin
        eval_sts = param_set_pkg::STS_OK;
        drop = 1'b0;
        go_flash = 1'b0;
        if (!etx_ok_r) begin
            eval_sts = param_set_pkg::STS_PACKET;
        end else if (sum_r != 8'h00) begin
            eval_sts = param_set_pkg::STS_CHECKSUM;
        end else if (!fmt_ok || len_r != param_set_pkg::CMD_LEN) begin
            eval_sts = param_set_pkg::STS_PACKET;
        end else if (cmd_r != param_set_pkg::CMD_PARAM_SET) begin
            drop = 1'b1; // other commands belong to other handlers
        end else if (!lifecycle_permit) begin
            eval_sts = param_set_pkg::STS_ACCEPT;
        end else if (!pid_ok) begin
            eval_sts = param_set_pkg::STS_PARAM;
        end else if (!auth_ok) begin
            eval_sts = param_set_pkg::STS_SECURE;
        end else if (enc_write_no_reset && pid_r == param_set_pkg::PID_L1_KEY) begin
            eval_sts = param_set_pkg::STS_ACCEPT;
        end else if (pval_r[2:0] != param_set_pkg::VAL_DISABLE) begin
            eval_sts = param_set_pkg::STS_PARAM;
        end else if (!already) begin
            go_flash = 1'b1; // already disabled needs no write
        end
    end

    // packet reception and command sequencing
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= ST_WAIT;
        end else begin
            unique case (state_r)
                ST_WAIT: if (rx_take && rx_data == param_set_pkg::HEADER_START_BYTE) begin
                    state_r <= ST_LEN_H;
                end
                ST_LEN_H: if (rx_take) state_r <= ST_LEN_L;
                ST_LEN_L: if (rx_take) state_r <= ST_BODY;
                ST_BODY: if (rx_take && body_cnt_r == body_len - 16'h0001) begin
                    state_r <= ST_SUM;
                end
                ST_SUM: if (rx_take) state_r <= ST_ETX;
                ST_ETX: if (rx_take) state_r <= ST_EVAL;
                ST_EVAL: begin
                    if (drop) state_r <= ST_WAIT;
                    else if (go_flash) state_r <= ST_FLASH;
                    else state_r <= ST_SEND;
                end
                ST_FLASH: if (flash_done) state_r <= ST_SEND;
                ST_SEND: if (tx_valid_r && tx_ready && idx_r == param_set_pkg::IDX_LAST) begin
                    state_r <= ST_WAIT;
                end
            endcase
        end
    end

    // captured fields and running sum of the command
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            len_r <= 16'h0000;
            body_cnt_r <= 16'h0000;
            sum_r <= 8'h00;
            cmd_r <= 8'h00;
            pid_r <= 8'h00;
            pval_r <= 8'h00;
            etx_ok_r <= 1'b0;
        end else if (rx_take) begin
            unique case (state_r)
                ST_WAIT: sum_r <= 8'h00;
                ST_LEN_H: begin
                    len_r[15:8] <= rx_data;
                    sum_r <= sum_r + rx_data;
                    body_cnt_r <= 16'h0000;
                end
                ST_LEN_L: begin
                    len_r[7:0] <= rx_data;
                    sum_r <= sum_r + rx_data;
                end
                ST_BODY: begin
                    if (body_cnt_r == 16'h0000) cmd_r <= rx_data;
                    if (body_cnt_r == 16'h0001) pid_r <= rx_data;
                    if (body_cnt_r == 16'h0002) pval_r <= rx_data; // bits 7:3 unused
                    sum_r <= sum_r + rx_data;
                    body_cnt_r <= body_cnt_r + 16'h0001;
                end
                ST_SUM: sum_r <= sum_r + rx_data; // zero when consistent
                ST_ETX: etx_ok_r <= (rx_data == param_set_pkg::TRAILER_BYTE);
                default: ;
            endcase
        end
    end

    // reply contents chosen at evaluation, flash result folded in later
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rsp_code_r <= param_set_pkg::REPLY_OK;
            sts_r <= param_set_pkg::STS_OK;
            detail_r <= param_set_pkg::UNUSED_WORD;
        end else if (state_r == ST_EVAL) begin
            sts_r <= eval_sts;
            detail_r <= param_set_pkg::UNUSED_WORD;
            rsp_code_r <= (eval_sts == param_set_pkg::STS_OK) ?
                param_set_pkg::REPLY_OK : param_set_pkg::REPLY_ERR;
        end else if (state_r == ST_FLASH && flash_done && flash_fail) begin
            sts_r <= param_set_pkg::STS_FLASH;
            detail_r <= flash_status;
            rsp_code_r <= param_set_pkg::REPLY_ERR;
        end
    end

    // flash request held until the flash unit answers
    assign flash_req = (state_r == ST_FLASH);
    assign flash_param_id = pid_r;

    // settings only ever gain bits; reload from storage once after reset
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            disabled_r <= 4'h0;
            loaded_r <= 1'b0;
        end else if (!loaded_r) begin
            disabled_r <= disabled_r | stored_settings;
            loaded_r <= 1'b1;
        end else if (state_r == ST_FLASH && flash_done && !flash_fail) begin
            disabled_r <= disabled_r | pid_bit;
        end
    end

    // downstream permissions, level two key loss also blocks init
    assign init_allowed = !disabled_r[param_set_pkg::BIT_INIT]
        && !disabled_r[param_set_pkg::BIT_L2_KEY];
    assign return_request_allowed = !disabled_r[param_set_pkg::BIT_L2_KEY];
    assign boot_lock_allowed = !disabled_r[param_set_pkg::BIT_BOOT_LOCK];
    assign level_two_key_allowed = !disabled_r[param_set_pkg::BIT_L2_KEY];
    assign level_one_key_allowed = !disabled_r[param_set_pkg::BIT_L1_KEY];

    // reply byte selected by position
    always_comb begin
        unique case (idx_r)
            4'h0: reply_byte = param_set_pkg::REPLY_START_BYTE;
            4'h1: reply_byte = param_set_pkg::REPLY_LEN[15:8];
            4'h2: reply_byte = param_set_pkg::REPLY_LEN[7:0];
            4'h3: reply_byte = rsp_code_r;
            4'h4: reply_byte = sts_r;
            4'h5: reply_byte = detail_r[31:24];
            4'h6: reply_byte = detail_r[23:16];
            4'h7: reply_byte = detail_r[15:8];
            4'h8: reply_byte = detail_r[7:0];
            4'h9: reply_byte = param_set_pkg::UNUSED_WORD[31:24];
            4'hA: reply_byte = param_set_pkg::UNUSED_WORD[23:16];
            4'hB: reply_byte = param_set_pkg::UNUSED_WORD[15:8];
            4'hC: reply_byte = param_set_pkg::UNUSED_WORD[7:0];
            param_set_pkg::IDX_SUM: reply_byte = 8'h00 - tx_sum_r;
            default: reply_byte = param_set_pkg::TRAILER_BYTE;
        endcase
    end

    // transmit one byte at a time, data held in a flop until taken
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            idx_r <= 4'h0;
            tx_sum_r <= 8'h00;
            tx_valid_r <= 1'b0;
            tx_data_r <= 8'h00;
        end else if (state_r == ST_SEND) begin
            if (!tx_valid_r) begin
                tx_valid_r <= 1'b1;
                tx_data_r <= reply_byte;
            end else if (tx_ready) begin
                tx_valid_r <= 1'b0;
                if (idx_r != 4'h0) tx_sum_r <= tx_sum_r + tx_data_r;
                idx_r <= (idx_r == param_set_pkg::IDX_LAST) ? 4'h0 : idx_r + 4'h1;
            end
        end else begin
            idx_r <= 4'h0;
            tx_sum_r <= 8'h00;
            tx_valid_r <= 1'b0;
        end
    end

    assign tx_valid = tx_valid_r;
    assign tx_data = tx_data_r;

    // bus answers one cycle after the request appears
    assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
    assign avs_readdata = rdata_r;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= (avs_read || avs_write) && !ack_r;
        end
    end

    // control register, writes land on the acknowledging edge
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            enable_r <= param_set_pkg::CTRL_ENABLE_RST;
        end else if (avs_write && ack_r && avs_address == param_set_pkg::REG_CTRL
                && avs_byteenable[0]) begin
            enable_r <= avs_writedata[param_set_pkg::CTRL_ENABLE_BIT];
        end
    end

    // last flash status kept for software
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            flash_sts_r <= 32'h0000_0000;
        end else if (state_r == ST_FLASH && flash_done) begin
            flash_sts_r <= flash_status;
        end
    end

    // read data registered; unmapped offsets read zero
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_r <= 32'h0000_0000;
        end else if (avs_read && !ack_r) begin
            unique case (avs_address)
                param_set_pkg::REG_CTRL: rdata_r <= {31'h0, enable_r};
                param_set_pkg::REG_STATUS: rdata_r <= {15'h0, state_r != ST_WAIT,
                    rsp_code_r, sts_r};
                param_set_pkg::REG_SETTINGS: rdata_r <= {28'h000_0000, disabled_r};
                param_set_pkg::REG_FLASH_STS: rdata_r <= flash_sts_r;
                default: rdata_r <= 32'h0000_0000;
            endcase
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    chk_soh_wait: assert property (state_r == ST_WAIT && rx_take
        && rx_data != param_set_pkg::HEADER_START_BYTE |=> state_r == ST_WAIT)
        else $error("non start byte left the wait state");
    chk_reply_start: assert property (tx_valid && idx_r == 4'h0
        |-> tx_data == param_set_pkg::REPLY_START_BYTE)
        else $error("reply does not open with start byte");
    chk_reply_trailer: assert property (tx_valid && idx_r == param_set_pkg::IDX_LAST
        |-> tx_data == param_set_pkg::TRAILER_BYTE)
        else $error("reply does not end with trailer");
    chk_no_write_err: assert property (state_r == ST_EVAL && !go_flash
        |=> !flash_req [*2])
        else $error("flash written after an error");
    chk_flash_fail: assert property (flash_req && flash_done && flash_fail
        |=> sts_r == param_set_pkg::STS_FLASH && detail_r == $past(flash_status))
        else $error("flash failure not reported");
    chk_settings_sticky: assert property ($past(disabled_r) == (disabled_r & $past(disabled_r)))
        else $error("a disabled setting was enabled again");
    chk_l2_cascade: assert property (disabled_r[param_set_pkg::BIT_L2_KEY]
        |-> !init_allowed && !return_request_allowed)
        else $error("level two key loss did not block init");
    chk_trailer_first: assert property (state_r == ST_EVAL && !etx_ok_r
        |=> sts_r == param_set_pkg::STS_PACKET ##1 state_r == ST_SEND)
        else $error("missing trailer not reported first");
    chk_bus_answer: assert property ((avs_read || avs_write) |-> ##[0:1] !avs_waitrequest)
        else $error("bus request not answered in one cycle");

    cov_ok_write: cover property (flash_req && flash_done && !flash_fail);
    cov_skip_write: cover property (state_r == ST_EVAL && eval_sts == param_set_pkg::STS_OK
        && !go_flash && !drop);
    cov_secure_err: cover property (state_r == ST_EVAL
        && eval_sts == param_set_pkg::STS_SECURE);
    cov_reply_done: cover property (tx_valid && tx_ready && idx_r == param_set_pkg::IDX_LAST);

endmodule

`default_nettype wire

// [rtl/param_set_pkg.sv]
// constants for the parameter setting command handler
package param_set_pkg;
    // packet framing bytes
    localparam logic [7:0] HEADER_START_BYTE = 8'h01;
    localparam logic [7:0] REPLY_START_BYTE = 8'h81;
    localparam logic [7:0] TRAILER_BYTE = 8'h03;
    localparam logic [7:0] CMD_PARAM_SET = 8'h51;
    localparam logic [7:0] REPLY_OK = 8'h51;
    localparam logic [7:0] REPLY_ERR = 8'hD1;
    localparam logic [15:0] CMD_LEN = 16'h0003;
    localparam logic [15:0] REPLY_LEN = 16'h000A;
    localparam logic [15:0] MAX_LEN_DEFAULT = 16'h0400;
    localparam logic [31:0] UNUSED_WORD = 32'h0FFF_FFFF;
    localparam int REPLY_BYTES = 15;
    localparam logic [3:0] IDX_SUM = 4'hD;
    localparam logic [3:0] IDX_LAST = 4'hE;
    // status codes
    localparam logic [7:0] STS_OK = 8'h00;
    localparam logic [7:0] STS_PACKET = 8'hC1;
    localparam logic [7:0] STS_CHECKSUM = 8'hC2;
    localparam logic [7:0] STS_ACCEPT = 8'hC3;
    localparam logic [7:0] STS_PARAM = 8'hC5;
    localparam logic [7:0] STS_SECURE = 8'hD0;
    localparam logic [7:0] STS_FLASH = 8'hE1;
    // parameter identifiers
    localparam logic [7:0] PID_INIT = 8'h01;
    localparam logic [7:0] PID_BOOT_LOCK = 8'h02;
    localparam logic [7:0] PID_L2_KEY = 8'h03;
    localparam logic [7:0] PID_L1_KEY = 8'h04;
    localparam logic [2:0] VAL_DISABLE = 3'h0;
    // authentication level encodings
    localparam logic [1:0] AUTH_LEVEL_ZERO = 2'h0;
    localparam logic [1:0] AUTH_LEVEL_ONE = 2'h1;
    localparam logic [1:0] AUTH_LEVEL_TWO = 2'h2;
    // register byte offsets
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_SETTINGS = 4'h8;
    localparam logic [3:0] REG_FLASH_STS = 4'hC;
    localparam int CTRL_ENABLE_BIT = 0;
    localparam logic CTRL_ENABLE_RST = 1'b1;
    localparam int STAT_BUSY_BIT = 16;
    // settings bit positions
    localparam int BIT_INIT = 0;
    localparam int BIT_BOOT_LOCK = 1;
    localparam int BIT_L2_KEY = 2;
    localparam int BIT_L1_KEY = 3;
endpackage
